/* logic/ccs_alu.sv */
`timescale 1ns/1ps
`default_nettype none

module ccs_alu (
  // Operation and operands
  input wire ccs_pkg::ccs_fn_t fn_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [7:0] flags_i,
  // Result and new flags
  output logic [7:0] res_o,
  output logic [7:0] flags_o
);

  // Shared adder: returns {v, h, c, result}; borrows for subtraction
  function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin, input logic sub);
    logic [7:0] bb;
    logic ci;
    logic [4:0] lo;
    logic [8:0] full;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    addsub = {(a[7] == bb[7]) && (full[7] != a[7]), lo[4] ^ sub, full[8] ^ sub, full[7:0]};
  endfunction : addsub

  logic [10:0] sum;

  // Flags follow the result of every operation
  always_comb begin
    sum = '0;
    res_o = a_i;
    flags_o = flags_i;
    unique case (fn_i)
      ccs_pkg::FN_ADD, ccs_pkg::FN_ADC, ccs_pkg::FN_SUB, ccs_pkg::FN_SBC,
      ccs_pkg::FN_NEG: begin
        if (fn_i == ccs_pkg::FN_NEG) begin
          sum = addsub(8'h00, a_i, 1'b0, 1'b1);
        end else begin
          sum = addsub(a_i, b_i,
                       flags_i[ccs_pkg::FB_C] && (fn_i == ccs_pkg::FN_ADC ||
                                                  fn_i == ccs_pkg::FN_SBC),
                       fn_i != ccs_pkg::FN_ADD && fn_i != ccs_pkg::FN_ADC);
        end
        res_o = sum[7:0];
        flags_o[ccs_pkg::FB_C] = sum[8];
        flags_o[ccs_pkg::FB_H] = sum[9];
        flags_o[ccs_pkg::FB_V] = sum[10];
      end
      ccs_pkg::FN_AND, ccs_pkg::FN_OR, ccs_pkg::FN_EOR, ccs_pkg::FN_COM: begin
        unique case (fn_i)
          ccs_pkg::FN_AND: res_o = a_i & b_i;
          ccs_pkg::FN_OR: res_o = a_i | b_i;
          ccs_pkg::FN_EOR: res_o = a_i ^ b_i;
          default: res_o = ~a_i;
        endcase
        flags_o[ccs_pkg::FB_V] = 1'b0;
        if (fn_i == ccs_pkg::FN_COM) begin
          flags_o[ccs_pkg::FB_C] = 1'b1;
        end
      end
      ccs_pkg::FN_INC, ccs_pkg::FN_DEC: begin
        // Carry is left alone so multi-byte loops keep it
        sum = addsub(a_i, 8'h01, 1'b0, fn_i == ccs_pkg::FN_DEC);
        res_o = sum[7:0];
        flags_o[ccs_pkg::FB_V] = sum[10];
      end
      ccs_pkg::FN_LSR, ccs_pkg::FN_ROR: begin
        res_o = {(fn_i == ccs_pkg::FN_ROR) && flags_i[ccs_pkg::FB_C], a_i[7:1]};
        flags_o[ccs_pkg::FB_C] = a_i[0];
        flags_o[ccs_pkg::FB_V] = res_o[7] ^ a_i[0];
      end
    endcase
    flags_o[ccs_pkg::FB_N] = res_o[7];
    // Carry-chained subtraction keeps zero only if all bytes were zero
    flags_o[ccs_pkg::FB_Z] = (res_o == 8'h00) &&
                             (fn_i != ccs_pkg::FN_SBC || flags_i[ccs_pkg::FB_Z]);
    flags_o[ccs_pkg::FB_S] = flags_o[ccs_pkg::FB_N] ^ flags_o[ccs_pkg::FB_V];
  end

endmodule : ccs_alu

`default_nettype wire

/* logic/ccs_core.sv */
`timescale 1ns/1ps
`default_nettype none

module ccs_core (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Decoded instruction from the sequencer
  input wire logic OP_VALID_I,
  input wire ccs_pkg::ccs_op_t OP_I,
  input wire ccs_pkg::ccs_fn_t ALU_FN_I,
  input wire logic [4:0] RD_I,
  input wire logic [4:0] RR_I,
  input wire logic [7:0] IMM_I,
  input wire logic USE_IMM_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire ccs_pkg::ccs_ptr_t PTR_SEL_I,
  input wire ccs_pkg::ccs_pmode_t PTR_MODE_I,
  input wire logic [5:0] DISP_I,
  input wire logic [15:0] RET_ADDR_I,
  input wire logic IRQ_PEND_I,
  // I/O space port
  input wire logic [5:0] IO_ADDR_I,
  input wire logic IO_WE_I,
  input wire logic IO_RE_I,
  input wire logic [7:0] IO_WDATA_I,
  output logic [7:0] IO_RDATA_O,
  // Data memory port
  output logic [15:0] DMEM_ADDR_O,
  output logic [7:0] DMEM_WDATA_O,
  output logic DMEM_WE_O,
  output logic DMEM_RE_O,
  input wire logic [7:0] DMEM_RDATA_I,
  // Status to the sequencer
  output logic BUSY_O,
  output logic [7:0] FLAGS_O,
  output logic [15:0] SP_O,
  output logic IRQ_GO_O,
  output logic [15:0] RET_PC_O,
  output logic RET_PC_VLD_O
);

  // Word flags for the pair add and subtract
  function automatic logic [7:0] wflags(input logic [7:0] f, input logic [15:0] a,
                                        input logic [15:0] r, input logic sub);
    logic [7:0] o;
    o = f;
    o[ccs_pkg::FB_V] = sub ? (a[15] && !r[15]) : (!a[15] && r[15]);
    o[ccs_pkg::FB_C] = sub ? (r[15] && !a[15]) : (a[15] && !r[15]);
    o[ccs_pkg::FB_N] = r[15];
    o[ccs_pkg::FB_Z] = (r == 16'h0000);
    o[ccs_pkg::FB_S] = o[ccs_pkg::FB_N] ^ o[ccs_pkg::FB_V];
    wflags = o;
  endfunction : wflags

  // Working registers; plain storage so they carry no reset
  logic [7:0] rf [ccs_pkg::NUM_REGS];

  // State registers
  ccs_pkg::ccs_state_t state_ff, nxt_state;
  logic [7:0] flags_ff, nxt_flags;
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic we_ff, nxt_we;
  logic re_ff, nxt_re;
  logic [4:0] ld_dst_ff, nxt_ld_dst;
  logic [7:0] hold_ff, nxt_hold;
  logic [15:0] ret_pc_ff, nxt_ret_pc;
  logic ret_vld_ff, nxt_ret_vld;
  logic busy_ff;
  logic irq_go_ff;
  logic [7:0] io_rdata_ff;

  // Four register write slots; later slots win on a clash
  logic wr_en [4];
  logic [4:0] wr_idx [4];
  logic [7:0] wr_dat [4];

  // Operand and pointer terms
  logic [7:0] op_a, op_b, alu_res, alu_flags;
  logic [4:0] pair_d, pair_r, ptr_base;
  logic [15:0] w_in, w_res, prod, ptr_val, ptr_ea, ptr_new;
  logic ptr_upd;

  // Operand fetch: one or two bytes, or one pair
  always_comb begin
    op_a = rf[RD_I];
    op_b = USE_IMM_I ? IMM_I : rf[RR_I];
    pair_d = {RD_I[4:1], 1'b0};
    pair_r = {RR_I[4:1], 1'b0};
    w_in = {rf[{RD_I[4:1], 1'b1}], rf[pair_d]};
    w_res = (OP_I == ccs_pkg::OP_SBIW) ? w_in - {10'h000, IMM_I[5:0]} :
                                         w_in + {10'h000, IMM_I[5:0]};
    prod = {8'h00, op_a} * {8'h00, rf[RR_I]};
  end

  // Pointer pairs and their addressing modes
  always_comb begin
    ptr_base = ccs_pkg::ptr_lo(PTR_SEL_I);
    ptr_val = {rf[{ptr_base[4:1], 1'b1}], rf[ptr_base]};
    ptr_ea = ptr_val;
    ptr_new = ptr_val;
    unique case (PTR_MODE_I)
      ccs_pkg::PM_PLAIN: ptr_ea = ptr_val;
      ccs_pkg::PM_POSTINC: ptr_new = ptr_val + ccs_pkg::STEP_BYTE;
      ccs_pkg::PM_PREDEC: begin
        ptr_new = ptr_val - ccs_pkg::STEP_BYTE;
        ptr_ea = ptr_new;
      end
      ccs_pkg::PM_DISP: ptr_ea = ptr_val + {10'h000, DISP_I};
    endcase
  end

  ccs_alu u_alu (
    .fn_i(ALU_FN_I),
    .a_i(op_a),
    .b_i(op_b),
    .flags_i(flags_ff),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // Execute: a new op is taken every clock while idle
  always_comb begin
    nxt_state = state_ff;
    nxt_flags = flags_ff;
    nxt_sp = sp_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_re = 1'b0;
    nxt_ld_dst = ld_dst_ff;
    nxt_hold = hold_ff;
    nxt_ret_pc = ret_pc_ff;
    nxt_ret_vld = 1'b0;
    ptr_upd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr_en[i] = 1'b0;
      wr_idx[i] = '0;
      wr_dat[i] = '0;
    end
    unique case (state_ff)
      ccs_pkg::ST_IDLE: if (OP_VALID_I) begin
        unique case (OP_I)
          ccs_pkg::OP_NOP: begin
          end
          ccs_pkg::OP_ALU: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = RD_I;
            wr_dat[0] = alu_res;
            nxt_flags = alu_flags;
          end
          ccs_pkg::OP_MOV: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = RD_I;
            wr_dat[0] = op_b;
          end
          ccs_pkg::OP_MOVW: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = pair_d;
            wr_dat[0] = rf[pair_r];
            wr_en[1] = 1'b1;
            wr_idx[1] = {RD_I[4:1], 1'b1};
            wr_dat[1] = rf[{RR_I[4:1], 1'b1}];
          end
          ccs_pkg::OP_ADIW, ccs_pkg::OP_SBIW: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = pair_d;
            wr_dat[0] = w_res[7:0];
            wr_en[1] = 1'b1;
            wr_idx[1] = {RD_I[4:1], 1'b1};
            wr_dat[1] = w_res[15:8];
            nxt_flags = wflags(flags_ff, w_in, w_res, OP_I == ccs_pkg::OP_SBIW);
          end
          ccs_pkg::OP_MUL: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = ccs_pkg::R_PROD_LO;
            wr_dat[0] = prod[7:0];
            wr_en[1] = 1'b1;
            wr_idx[1] = ccs_pkg::R_PROD_HI;
            wr_dat[1] = prod[15:8];
            nxt_flags[ccs_pkg::FB_C] = prod[15];
            nxt_flags[ccs_pkg::FB_Z] = (prod == 16'h0000);
          end
          ccs_pkg::OP_LD: begin
            ptr_upd = 1'b1;
            if (ptr_ea < ccs_pkg::REG_SPACE_TOP) begin
              wr_en[0] = 1'b1;
              wr_idx[0] = RD_I;
              wr_dat[0] = rf[ptr_ea[4:0]];
            end else begin
              nxt_addr = ptr_ea;
              nxt_re = 1'b1;
              nxt_ld_dst = RD_I;
              nxt_state = ccs_pkg::ST_LOAD;
            end
          end
          ccs_pkg::OP_ST: begin
            ptr_upd = 1'b1;
            if (ptr_ea < ccs_pkg::REG_SPACE_TOP) begin
              wr_en[0] = 1'b1;
              wr_idx[0] = ptr_ea[4:0];
              wr_dat[0] = rf[RR_I];
            end else begin
              nxt_addr = ptr_ea;
              nxt_wdata = rf[RR_I];
              nxt_we = 1'b1;
            end
          end
          ccs_pkg::OP_PUSH: begin
            nxt_addr = sp_ff;
            nxt_wdata = rf[RR_I];
            nxt_we = 1'b1;
            nxt_sp = sp_ff - ccs_pkg::STEP_BYTE;
          end
          ccs_pkg::OP_POP: begin
            nxt_sp = sp_ff + ccs_pkg::STEP_BYTE;
            nxt_addr = nxt_sp;
            nxt_re = 1'b1;
            nxt_ld_dst = RD_I;
            nxt_state = ccs_pkg::ST_LOAD;
          end
          ccs_pkg::OP_CALL, ccs_pkg::OP_INTR: begin
            // Only the return address goes on the stack, never the flags
            nxt_addr = sp_ff;
            nxt_wdata = RET_ADDR_I[7:0];
            nxt_we = 1'b1;
            nxt_hold = RET_ADDR_I[15:8];
            nxt_sp = sp_ff - ccs_pkg::STEP_ADDR;
            nxt_state = ccs_pkg::ST_CALL_HI;
            if (OP_I == ccs_pkg::OP_INTR) begin
              nxt_flags[ccs_pkg::FB_I] = 1'b0;
            end
          end
          ccs_pkg::OP_RET, ccs_pkg::OP_INTERRUPT_RETURN_INSTR: begin
            nxt_addr = sp_ff + ccs_pkg::STEP_BYTE;
            nxt_re = 1'b1;
            nxt_sp = sp_ff + ccs_pkg::STEP_ADDR;
            nxt_state = ccs_pkg::ST_RET_HI;
            if (OP_I == ccs_pkg::OP_INTERRUPT_RETURN_INSTR) begin
              nxt_flags[ccs_pkg::FB_I] = 1'b1;
            end
          end
          ccs_pkg::OP_SEI: nxt_flags[ccs_pkg::FB_I] = 1'b1;
          ccs_pkg::OP_CLI: nxt_flags[ccs_pkg::FB_I] = 1'b0;
          ccs_pkg::OP_BST: nxt_flags[ccs_pkg::FB_T] = op_a[BIT_SEL_I];
          ccs_pkg::OP_BLD: begin
            wr_en[0] = 1'b1;
            wr_idx[0] = RD_I;
            wr_dat[0] = op_a;
            wr_dat[0][BIT_SEL_I] = flags_ff[ccs_pkg::FB_T];
          end
        endcase
      end
      ccs_pkg::ST_LOAD: begin
        wr_en[0] = 1'b1;
        wr_idx[0] = ld_dst_ff;
        wr_dat[0] = DMEM_RDATA_I;
        nxt_state = ccs_pkg::ST_IDLE;
      end
      ccs_pkg::ST_CALL_HI: begin
        nxt_addr = addr_ff - ccs_pkg::STEP_BYTE;
        nxt_wdata = hold_ff;
        nxt_we = 1'b1;
        nxt_state = ccs_pkg::ST_IDLE;
      end
      ccs_pkg::ST_RET_HI: begin
        nxt_hold = DMEM_RDATA_I;
        nxt_addr = addr_ff + ccs_pkg::STEP_BYTE;
        nxt_re = 1'b1;
        nxt_state = ccs_pkg::ST_RET_LO;
      end
      ccs_pkg::ST_RET_LO: begin
        nxt_ret_pc = {hold_ff, DMEM_RDATA_I};
        nxt_ret_vld = 1'b1;
        nxt_state = ccs_pkg::ST_IDLE;
      end
    endcase
    // Pointer write-back takes the last slots so it wins over a load from register space
    if (ptr_upd && PTR_MODE_I inside {ccs_pkg::PM_POSTINC, ccs_pkg::PM_PREDEC}) begin
      wr_en[2] = 1'b1;
      wr_idx[2] = ptr_base;
      wr_dat[2] = ptr_new[7:0];
      wr_en[3] = 1'b1;
      wr_idx[3] = {ptr_base[4:1], 1'b1};
      wr_dat[3] = ptr_new[15:8];
    end
    // An I/O write is itself an instruction, so the flags or stack pointer byte it writes overrides the op's
    if (IO_WE_I) begin
      unique case (IO_ADDR_I)
        ccs_pkg::IO_CPU_FLAGS: begin
          nxt_flags = IO_WDATA_I;
          nxt_flags[ccs_pkg::FB_S] = IO_WDATA_I[ccs_pkg::FB_N] ^
                                     IO_WDATA_I[ccs_pkg::FB_V];
        end
        ccs_pkg::IO_SP_LOW: nxt_sp[7:0] = IO_WDATA_I;
        ccs_pkg::IO_SP_HIGH: nxt_sp[15:8] = IO_WDATA_I;
        default: begin
        end
      endcase
    end
  end

  // Register file write; runs straight on the chip clock
  always_ff @(posedge MCLK_I) begin
    for (int i = 0; i < 4; i++) begin
      if (wr_en[i]) begin
        rf[wr_idx[i]] <= wr_dat[i];
      end
    end
  end

  // Flags; not touched by interrupt entry or return except bit 7
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags_ff <= ccs_pkg::FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Stack pointer
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sp_ff <= ccs_pkg::SP_RST;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // Sequencer state and busy flag
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= ccs_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      ld_dst_ff <= '0;
      hold_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != ccs_pkg::ST_IDLE);
      ld_dst_ff <= nxt_ld_dst;
      hold_ff <= nxt_hold;
    end
  end

  // Data memory request
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_ff <= '0;
      wdata_ff <= '0;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
    end
  end

  // Return address handed back to the sequencer
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ret_pc_ff <= '0;
      ret_vld_ff <= 1'b0;
    end else begin
      ret_pc_ff <= nxt_ret_pc;
      ret_vld_ff <= nxt_ret_vld;
    end
  end

  // Interrupt gate uses the next flag value so a clear blocks at once
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_go_ff <= 1'b0;
    end else begin
      irq_go_ff <= nxt_flags[ccs_pkg::FB_I] && IRQ_PEND_I;
    end
  end

  // I/O read data; unmapped offsets read as zero
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      io_rdata_ff <= '0;
    end else if (IO_RE_I) begin
      unique case (IO_ADDR_I)
        ccs_pkg::IO_CPU_FLAGS: io_rdata_ff <= flags_ff;
        ccs_pkg::IO_SP_LOW: io_rdata_ff <= sp_ff[7:0];
        ccs_pkg::IO_SP_HIGH: io_rdata_ff <= sp_ff[15:8];
        default: io_rdata_ff <= '0;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign IO_RDATA_O = io_rdata_ff;
  assign DMEM_ADDR_O = addr_ff;
  assign DMEM_WDATA_O = wdata_ff;
  assign DMEM_WE_O = we_ff;
  assign DMEM_RE_O = re_ff;
  assign BUSY_O = busy_ff;
  assign FLAGS_O = flags_ff;
  assign SP_O = sp_ff;
  assign IRQ_GO_O = irq_go_ff;
  assign RET_PC_O = ret_pc_ff;
  assign RET_PC_VLD_O = ret_vld_ff;

endmodule : ccs_core

`default_nettype wire

/* logic/ccs_pkg.sv */
`default_nettype none

package ccs_pkg;

  // Register file geometry
  localparam int NUM_REGS = 32;
  localparam logic [15:0] REG_SPACE_TOP = 16'h0020;
  localparam logic [4:0] R_X_LO = 5'h1a;
  localparam logic [4:0] R_Y_LO = 5'h1c;
  localparam logic [4:0] R_Z_LO = 5'h1e;
  localparam logic [4:0] R_PROD_LO = 5'h00;
  localparam logic [4:0] R_PROD_HI = 5'h01;

  // I/O space offsets of the core registers
  localparam logic [5:0] IO_SP_LOW = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  localparam logic [5:0] IO_CPU_FLAGS = 6'h3f;

  // Reset values
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Flag bit positions
  localparam int FB_C = 0;
  localparam int FB_Z = 1;
  localparam int FB_N = 2;
  localparam int FB_V = 3;
  localparam int FB_S = 4;
  localparam int FB_H = 5;
  localparam int FB_T = 6;
  localparam int FB_I = 7;

  // Stack and pointer steps
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_ADDR = 16'h0002;

  // Decoded operations
  typedef enum logic [4:0] {
    OP_NOP, OP_ALU, OP_MOV, OP_MOVW, OP_ADIW, OP_SBIW, OP_MUL,
    OP_LD, OP_ST, OP_PUSH, OP_POP, OP_CALL, OP_INTR, OP_RET, OP_INTERRUPT_RETURN_INSTR,
    OP_SEI, OP_CLI, OP_BST, OP_BLD
  } ccs_op_t;

  // Eight-bit arithmetic unit functions
  typedef enum logic [3:0] {
    FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_AND, FN_OR, FN_EOR,
    FN_COM, FN_NEG, FN_INC, FN_DEC, FN_LSR, FN_ROR
  } ccs_fn_t;

  typedef enum logic [1:0] {PM_PLAIN, PM_POSTINC, PM_PREDEC, PM_DISP} ccs_pmode_t;
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z, PTR_BAD} ccs_ptr_t;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_CALL_HI, ST_RET_HI, ST_RET_LO} ccs_state_t;

  // Low register of a pointer pair
  function automatic logic [4:0] ptr_lo(input ccs_ptr_t sel);
    unique case (sel)
      PTR_X: ptr_lo = R_X_LO;
      PTR_Y: ptr_lo = R_Y_LO;
      default: ptr_lo = R_Z_LO;
    endcase
  endfunction : ptr_lo

endpackage : ccs_pkg

`default_nettype wire

/* testbench/ccs_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_core_asserts (
  // Clock, reset and requests
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic OP_VALID_I,
  input wire ccs_pkg::ccs_op_t OP_I,
  input wire logic IRQ_PEND_I,
  input wire logic IO_WE_I,
  // Design outputs
  input wire logic [15:0] DMEM_ADDR_O,
  input wire logic DMEM_WE_O,
  input wire logic DMEM_RE_O,
  input wire logic BUSY_O,
  input wire logic [7:0] FLAGS_O,
  input wire logic [15:0] SP_O,
  input wire logic IRQ_GO_O,
  input wire logic RET_PC_VLD_O
);
  // Op taken with no I/O write racing it, since an I/O write wins
  logic tk;
  assign tk = OP_VALID_I && !BUSY_O && !IO_WE_I;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_sp_reset_zero: assert property ($rose(RST_N_I) |-> SP_O == 16'h0000)
    else $error("stack pointer not zero after reset");
  chk_sign_bit: assert property (FLAGS_O[4] == (FLAGS_O[2] ^ FLAGS_O[3]))
    else $error("sign flag differs from negative xor overflow");
  chk_push_step: assert property (tk && OP_I == ccs_pkg::OP_PUSH |=>
    SP_O == $past(SP_O) - 16'h0001 && DMEM_WE_O && DMEM_ADDR_O == $past(SP_O))
    else $error("push did not store at old top and step down by one");
  chk_pop_step: assert property (tk && OP_I == ccs_pkg::OP_POP |=>
    SP_O == $past(SP_O) + 16'h0001 && DMEM_RE_O && DMEM_ADDR_O == SP_O)
    else $error("pop did not step up by one");
  chk_call_step: assert property (tk && OP_I == ccs_pkg::OP_CALL |=>
    SP_O == $past(SP_O) - 16'h0002 ##1 DMEM_WE_O && DMEM_ADDR_O == $past(SP_O, 2) - 16'h0001)
    else $error("call did not push two bytes and step down by two");
  chk_ret_step: assert property (tk && OP_I inside {ccs_pkg::OP_RET, ccs_pkg::OP_INTERRUPT_RETURN_INSTR} |=>
    SP_O == $past(SP_O) + 16'h0002 ##0 BUSY_O [*2] ##1 (!BUSY_O && RET_PC_VLD_O))
    else $error("return did not step up by two or pulse late");
  chk_gate_sei_cli: assert property (tk && OP_I inside {ccs_pkg::OP_SEI, ccs_pkg::OP_CLI} |=>
    FLAGS_O[7] == ($past(OP_I) == ccs_pkg::OP_SEI)) else $error("gate bit wrong after set or clear");
  chk_intr_flags: assert property (tk && OP_I == ccs_pkg::OP_INTR |=>
    FLAGS_O == ($past(FLAGS_O) & 8'h7f)) else $error("interrupt entry altered flags wrongly");
  chk_interrupt_return_instr_gate: assert property (tk && OP_I == ccs_pkg::OP_INTERRUPT_RETURN_INSTR |=> FLAGS_O[7])
    else $error("interrupt return left gate clear");
  chk_irq_gate: assert property (IRQ_GO_O |-> FLAGS_O[7] && $past(IRQ_PEND_I))
    else $error("interrupt taken with gate clear");
endmodule : ccs_core_asserts
bind ccs_core ccs_core_asserts i_ccs_core_asserts (.*);
`default_nettype wire

/* testbench/ccs_dmem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_dmem_model (
  // Memory port
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h5a;
  // Byte write on the strobe edge, and last read byte kept
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) last <= mem[addr_i];
  end
  // Idle bus shows the inverse of the last byte so stale data cannot pass
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule : ccs_dmem_model
`default_nettype wire

/* testbench/cpu_core_status_stack_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_status_stack_tb;
  logic MCLK_I, RST_N_I, OP_VALID_I, USE_IMM_I, IRQ_PEND_I, IO_WE_I, IO_RE_I;
  logic DMEM_WE_O, DMEM_RE_O, BUSY_O, IRQ_GO_O, RET_PC_VLD_O;
  ccs_pkg::ccs_op_t OP_I;
  ccs_pkg::ccs_fn_t ALU_FN_I;
  ccs_pkg::ccs_ptr_t PTR_SEL_I;
  ccs_pkg::ccs_pmode_t PTR_MODE_I;
  logic [4:0] RD_I, RR_I;
  logic [7:0] IMM_I, IO_WDATA_I, IO_RDATA_O, DMEM_WDATA_O, DMEM_RDATA_I, FLAGS_O;
  logic [2:0] BIT_SEL_I;
  logic [5:0] DISP_I, IO_ADDR_I;
  logic [15:0] RET_ADDR_I, DMEM_ADDR_O, SP_O, RET_PC_O, sp;
  int n_errors, checked;
  ccs_core i_ccs_core (.*);
  ccs_dmem_model i_ccs_dmem_model (.clk_i(MCLK_I), .addr_i(DMEM_ADDR_O), .wdata_i(DMEM_WDATA_O),
    .we_i(DMEM_WE_O), .re_i(DMEM_RE_O), .rdata_o(DMEM_RDATA_I));
  // 50 MHz clock
  initial begin
    MCLK_I = 1'b0;
    forever #10 MCLK_I = ~MCLK_I;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic tick();
    @(posedge MCLK_I);
    #1;
  endtask : tick
  // Idle edge first so valid never falls and rises at once, then one op and a bounded busy wait
  task automatic op(input ccs_pkg::ccs_op_t o, input logic [4:0] d, input logic [4:0] r);
    tick();
    OP_I = o;
    RD_I = d;
    RR_I = r;
    OP_VALID_I = 1'b1;
    tick();
    OP_VALID_I = 1'b0;
    for (int k = 0; k < 4 && BUSY_O !== 1'b0; k++) tick();
    if (BUSY_O !== 1'b0) begin
      n_errors++;
      finish_test();
    end
  endtask : op
  task automatic mov(input logic [4:0] d, input logic [7:0] v);
    USE_IMM_I = 1'b1;
    IMM_I = v;
    op(ccs_pkg::OP_MOV, d, 5'h00);
  endtask : mov
  task automatic io(input logic we, input logic [5:0] a, input logic [7:0] d);
    tick();
    IO_ADDR_I = a;
    IO_WDATA_I = d;
    IO_WE_I = we;
    IO_RE_I = !we;
    tick();
    IO_WE_I = 1'b0;
    IO_RE_I = 1'b0;
  endtask : io
  // Push a register and compare the stored byte and the new top
  task automatic push_chk(input logic [4:0] r, input logic [7:0] e);
    op(ccs_pkg::OP_PUSH, 5'h00, r);
    tick();
    sp = sp - 16'h0001;
    chk(SP_O, sp);
    chk(i_ccs_dmem_model.mem[sp + 16'h0001], e);
  endtask : push_chk
  task automatic t_regs();
    for (int a = 61; a < 64; a++) begin
      io(1'b0, 6'(a), 8'h00);
      chk(IO_RDATA_O, 16'h0000);
    end
    io(1'b1, 6'h3e, 8'h03);
    io(1'b1, 6'h3d, 8'h40);
    io(1'b0, 6'h3e, 8'h00);
    chk(IO_RDATA_O, 16'h0003);
    chk(SP_O, sp);
    io(1'b1, 6'h3f, 8'hff);
    io(1'b0, 6'h3f, 8'h00);
    chk(IO_RDATA_O, 16'h00ef);
    io(1'b1, 6'h00, 8'h55);
    io(1'b0, 6'h00, 8'h00);
    chk(IO_RDATA_O, 16'h0000);
  endtask : t_regs
  task automatic alu(input ccs_pkg::ccs_fn_t f, input logic [7:0] a, b, r, fl, m);
    mov(5'h10, a);
    mov(5'h11, b);
    ALU_FN_I = f;
    USE_IMM_I = 1'b0;
    op(ccs_pkg::OP_ALU, 5'h10, 5'h11);
    chk(FLAGS_O & m, fl);
    push_chk(5'h10, r);
  endtask : alu
  task automatic t_alu();
    alu(ccs_pkg::FN_ADD, 8'h7f, 8'h01, 8'h80, 8'h2c, 8'h3f);
    alu(ccs_pkg::FN_ADD, 8'hff, 8'h01, 8'h00, 8'h23, 8'h3f);
    alu(ccs_pkg::FN_SUB, 8'h00, 8'h01, 8'hff, 8'h35, 8'h3f);
    alu(ccs_pkg::FN_SUB, 8'h80, 8'h01, 8'h7f, 8'h38, 8'h3f);
    alu(ccs_pkg::FN_AND, 8'hf0, 8'h0f, 8'h00, 8'h02, 8'h1e);
    alu(ccs_pkg::FN_EOR, 8'h80, 8'h00, 8'h80, 8'h14, 8'h1e);
    mov(5'h14, 8'ha5);
    push_chk(5'h14, 8'ha5);
    op(ccs_pkg::OP_POP, 5'h15, 5'h00);
    sp = sp + 16'h0001;
    chk(SP_O, sp);
    push_chk(5'h15, 8'ha5);
  endtask : t_alu
  task automatic t_call();
    RET_ADDR_I = 16'h1234;
    op(ccs_pkg::OP_CALL, 5'h00, 5'h00);
    tick();
    sp = sp - 16'h0002;
    chk(SP_O, sp);
    chk({i_ccs_dmem_model.mem[sp + 16'h0001],
         i_ccs_dmem_model.mem[sp + 16'h0002]}, 16'h1234);
    op(ccs_pkg::OP_RET, 5'h00, 5'h00);
    chk(RET_PC_VLD_O, 16'h0001);
    chk(RET_PC_O, 16'h1234);
    sp = sp + 16'h0002;
    chk(SP_O, sp);
  endtask : t_call
  task automatic t_irq();
    io(1'b1, 6'h3f, 8'h00);
    IRQ_PEND_I = 1'b1;
    tick();
    chk(IRQ_GO_O, 16'h0000);
    op(ccs_pkg::OP_SEI, 5'h00, 5'h00);
    chk(IRQ_GO_O, 16'h0001);
    op(ccs_pkg::OP_CLI, 5'h00, 5'h00);
    chk(IRQ_GO_O, 16'h0000);
    io(1'b1, 6'h3f, 8'h83);
    RET_ADDR_I = 16'h0456;
    op(ccs_pkg::OP_INTR, 5'h00, 5'h00);
    chk(FLAGS_O, 16'h0003);
    op(ccs_pkg::OP_INTERRUPT_RETURN_INSTR, 5'h00, 5'h00);
    chk(RET_PC_O, 16'h0456);
    chk(FLAGS_O, 16'h0083);
    IRQ_PEND_I = 1'b0;
  endtask : t_irq
  task automatic t_bit_ptr();
    mov(5'h05, 8'h08);
    mov(5'h06, 8'h00);
    BIT_SEL_I = 3'h3;
    op(ccs_pkg::OP_BST, 5'h05, 5'h00);
    chk(FLAGS_O[6], 16'h0001);
    BIT_SEL_I = 3'h7;
    op(ccs_pkg::OP_BLD, 5'h06, 5'h00);
    push_chk(5'h06, 8'h80);
    mov(5'h1a, 8'h00);
    mov(5'h1b, 8'h02);
    mov(5'h07, 8'h3c);
    PTR_MODE_I = ccs_pkg::PM_POSTINC;
    op(ccs_pkg::OP_ST, 5'h00, 5'h07);
    PTR_MODE_I = ccs_pkg::PM_PREDEC;
    op(ccs_pkg::OP_ST, 5'h00, 5'h05);
    DISP_I = 6'h05;
    PTR_MODE_I = ccs_pkg::PM_DISP;
    op(ccs_pkg::OP_ST, 5'h00, 5'h07);
    tick();
    chk(i_ccs_dmem_model.mem[16'h0200], 16'h0008);
    chk(i_ccs_dmem_model.mem[16'h0205], 16'h003c);
    mov(5'h1a, 8'h09);
    mov(5'h1b, 8'h00);
    PTR_MODE_I = ccs_pkg::PM_PLAIN;
    op(ccs_pkg::OP_ST, 5'h00, 5'h07);
    push_chk(5'h09, 8'h3c);
  endtask : t_bit_ptr
  // Word schemes, product and the second and third pointers
  task automatic t_wide();
    mov(5'h02, 8'hff);
    mov(5'h03, 8'h12);
    op(ccs_pkg::OP_MOVW, 5'h18, 5'h02);
    IMM_I = 8'h01;
    op(ccs_pkg::OP_ADIW, 5'h18, 5'h00);
    push_chk(5'h19, 8'h13);
    op(ccs_pkg::OP_MUL, 5'h02, 5'h03);
    push_chk(5'h01, 8'h11);
    mov(5'h1c, 8'h00);
    mov(5'h1d, 8'h03);
    mov(5'h1e, 8'h01);
    mov(5'h1f, 8'h03);
    PTR_SEL_I = ccs_pkg::PTR_Y;
    op(ccs_pkg::OP_ST, 5'h00, 5'h03);
    PTR_SEL_I = ccs_pkg::PTR_Z;
    op(ccs_pkg::OP_ST, 5'h00, 5'h02);
    op(ccs_pkg::OP_LD, 5'h08, 5'h00);
    push_chk(5'h08, 8'hff);
    chk(i_ccs_dmem_model.mem[16'h0300], 16'h0012);
  endtask : t_wide
  // Reset, then the scenarios in turn
  initial begin
    {OP_VALID_I, USE_IMM_I, IRQ_PEND_I, IO_WE_I, IO_RE_I, RST_N_I} = '0;
    {RD_I, RR_I, IMM_I, IO_WDATA_I, BIT_SEL_I, DISP_I, IO_ADDR_I, RET_ADDR_I} = '0;
    OP_I = ccs_pkg::OP_NOP;
    ALU_FN_I = ccs_pkg::FN_ADD;
    PTR_SEL_I = ccs_pkg::PTR_X;
    PTR_MODE_I = ccs_pkg::PM_PLAIN;
    n_errors = 0;
    checked = 0;
    sp = 16'h0340;
    repeat (6) @(posedge MCLK_I);
    #1;
    RST_N_I = 1'b1;
    t_regs();
    t_alu();
    t_call();
    t_irq();
    t_bit_ptr();
    t_wide();
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge MCLK_I);
    n_errors++;
    finish_test();
  end
endmodule : cpu_core_status_stack_tb
`default_nettype wire
